// ---- include/osfm_pkg.sv ----
// Operation
// - Crystal modes count 1024 external oscillator cycles before trusting the oscillator.
// - Start-up count runs after power-up delay expiry and on every wake-up.
// - During the count the core is held unless fail-safe or two-speed is enabled.
// - With fail-safe or two-speed enabled, code runs from internal clock during count.
// - Monitoring works only with its enable bit, in every external oscillator mode.
// - Failure is declared only after the start-up count has expired.
// - Sample clock is the low-frequency internal oscillator divided by 64.
// - Latch set on external falling edge, cleared on sample clock rising edge.
// - Failure when a whole sample half period passes without external clock low.
// - On failure switch system clock to internal and set oscillator-fail flag.
// - Interrupt requested when fail flag and its enable are both set.
// - System clock stays internal until firmware restarts and switches back successfully.
// - Internal frequency after failure is the 4-bit internal frequency select field.
// - Fail state cleared by reset, sleep entry, or a change of source select.
// - Source select change restarts the count; run internal until count and switch finish.
// - If the external clock still fails after switch-back, the flag sets again; in crystal modes the count never ends and the flag stays clear.
// - External clock and RC modes skip the count; monitoring starts at once.
// - Enabling fail-safe monitoring also enables two-speed start-up.
package osfm_pkg;

   // =========================================================
   // Register indices
   localparam logic [2:0] OFS_OSC_CONTROL   = 3'h0;
   localparam logic [2:0] OFS_OSC_STATUS    = 3'h1;
   localparam logic [2:0] OFS_IRQ_FLAGS_2   = 3'h2;
   localparam logic [2:0] OFS_IRQ_ENABLES_2 = 3'h3;
   localparam logic [2:0] OFS_CONFIG        = 3'h4;

   // =========================================================
   // Field positions
   localparam int SRC_LSB      = 0;
   localparam int IFS_LSB      = 3;
   localparam int OSC_FAIL_BIT = 7;
   localparam int CFG_FSM_BIT  = 0;
   localparam int CFG_TWO_BIT  = 1;
   localparam int CFG_MODE_LSB = 2;
   localparam int STS_DONE_BIT = 0;
   localparam int STS_EXT_BIT  = 1;
   localparam int STS_FAIL_BIT = 2;
   localparam int STS_RUN_BIT  = 3;

   // =========================================================
   // Reset values and encodings
   localparam logic [1:0] SRC_PRIMARY    = 2'h0;
   localparam logic [1:0] SRC_RESET      = 2'h0;
   localparam logic [3:0] IFS_RESET      = 4'h7;
   localparam logic [7:0] CONFIG_RESET   = 8'h00;

   // =========================================================
   // Timing counts
   localparam int STARTUP_CYCLES = 1024;
   localparam int SAMPLE_DIVIDE  = 64;
   localparam int SAMPLE_HALF    = SAMPLE_DIVIDE / 2;

   // =========================================================
   // Oscillator modes and start-up states
   typedef enum logic [2:0] {
      MODE_LOW_POWER_CRYSTAL  = 3'h0,
      MODE_CRYSTAL            = 3'h1,
      MODE_HIGH_SPEED_CRYSTAL = 3'h2,
      MODE_EXTERNAL_CLOCK     = 3'h3,
      MODE_RESISTOR_CAP       = 3'h4,
      MODE_SECONDARY          = 3'h5
   } osfm_mode_t;

   typedef enum logic [1:0] {
      ST_POWERUP_WAIT,
      ST_ASLEEP,
      ST_COUNTING,
      ST_READY
   } osfm_state_t;

endpackage

// ---- rtl/osfm_top.sv ----
`timescale 1ns/1ns
module osfm_top #(
   parameter int STARTUP_COUNT = osfm_pkg::STARTUP_CYCLES,
   parameter int SAMPLE_DIV    = osfm_pkg::SAMPLE_DIVIDE
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       extClkPin,
   input  wire logic       lowFreqOscPin,
   input  wire logic       powerupDelayDone,
   input  wire logic       sleepEntry,
   input  wire logic       wakeFromSleep,
   input  wire logic [2:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   output logic            sysClkExternal,
   output logic            cpuHold,
   output logic            oscFailIrq,
   output logic      [3:0] internalFreqSelect,
   output logic            oscStarted
);

   localparam int OW = $clog2(STARTUP_COUNT);
   localparam int DW = $clog2(SAMPLE_DIV);
   localparam logic [OW-1:0] CNT_LAST = OW'(STARTUP_COUNT - 1);
   localparam logic [DW-1:0] DIV_HALF = DW'(SAMPLE_DIV / 2);

   // =========================================================
   // Elaboration checks
   if (STARTUP_COUNT < 2 || (STARTUP_COUNT & (STARTUP_COUNT - 1)) != 0) begin : g_chk_startup
      $error("STARTUP_COUNT must be a power of two of at least 2");
   end
   if (SAMPLE_DIV < 4 || (SAMPLE_DIV & (SAMPLE_DIV - 1)) != 0) begin : g_chk_div
      $error("SAMPLE_DIV must be a power of two of at least 4");
   end

   // =========================================================
   // Pin synchronisers
   logic [2:0] extSync_q;
   logic [2:0] extSync_d;
   logic [2:0] lfSync_q;
   logic [2:0] lfSync_d;
   logic       extFall;
   logic       lfRise;

   // Two stages, third stage only for edge detection
   always_comb begin
      extSync_d = {extSync_q[1:0], extClkPin};
      lfSync_d  = {lfSync_q[1:0], lowFreqOscPin};
   end

   // Synchroniser flops
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         extSync_q <= 3'h0;
         lfSync_q  <= 3'h0;
      end else begin
         extSync_q <= extSync_d;
         lfSync_q  <= lfSync_d;
      end
   end

   assign extFall = extSync_q[2] & ~extSync_q[1];
   assign lfRise  = ~lfSync_q[2] & lfSync_q[1];

   // =========================================================
   // Registers
   logic [1:0] srcSel_q;
   logic [1:0] srcSel_d;
   logic [3:0] ifs_q;
   logic [3:0] ifs_d;
   logic [7:0] config_q;
   logic [7:0] config_d;
   logic       failFlag_q;
   logic       failFlag_d;
   logic       failIrqEn_q;
   logic       failIrqEn_d;
   logic       srcChange;
   logic       monitorEnable;
   logic       twoSpeedEff;
   logic       countMode;
   logic       failDetect;
   logic       failState_q;

   assign srcChange     = regWr && regAddr == osfm_pkg::OFS_OSC_CONTROL
                          && regWrData[osfm_pkg::SRC_LSB +: 2] != srcSel_q;
   assign monitorEnable = config_q[osfm_pkg::CFG_FSM_BIT];
   assign twoSpeedEff   = config_q[osfm_pkg::CFG_TWO_BIT] | monitorEnable;
   // Only crystal and resonator modes need the start-up count
   assign countMode     = config_q[osfm_pkg::CFG_MODE_LSB +: 3] <= 3'h2;

   // Register writes; hardware set of the fail flag wins
   always_comb begin
      srcSel_d    = srcSel_q;
      ifs_d       = ifs_q;
      config_d    = config_q;
      failFlag_d  = failFlag_q;
      failIrqEn_d = failIrqEn_q;
      if (regWr) begin
         case (regAddr)
            osfm_pkg::OFS_OSC_CONTROL: begin
               srcSel_d = regWrData[osfm_pkg::SRC_LSB +: 2];
               ifs_d    = regWrData[osfm_pkg::IFS_LSB +: 4];
            end
            osfm_pkg::OFS_IRQ_FLAGS_2:   failFlag_d  = regWrData[osfm_pkg::OSC_FAIL_BIT];
            osfm_pkg::OFS_IRQ_ENABLES_2: failIrqEn_d = regWrData[osfm_pkg::OSC_FAIL_BIT];
            osfm_pkg::OFS_CONFIG:        config_d    = regWrData;
            default: ;
         endcase
      end
      if (failDetect) begin
         failFlag_d = 1'b1;
      end
   end

   // Software-visible register flops
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         srcSel_q    <= osfm_pkg::SRC_RESET;
         ifs_q       <= osfm_pkg::IFS_RESET;
         config_q    <= osfm_pkg::CONFIG_RESET;
         failFlag_q  <= 1'b0;
         failIrqEn_q <= 1'b0;
      end else begin
         srcSel_q    <= srcSel_d;
         ifs_q       <= ifs_d;
         config_q    <= config_d;
         failFlag_q  <= failFlag_d;
         failIrqEn_q <= failIrqEn_d;
      end
   end

   // =========================================================
   // Start-up sequencer and counter
   osfm_pkg::osfm_state_t state_q;
   osfm_pkg::osfm_state_t state_d;
   logic [OW-1:0]         startCnt_q;
   logic [OW-1:0]         startCnt_d;
   logic                  restart;

   assign restart = (state_q == osfm_pkg::ST_POWERUP_WAIT && powerupDelayDone)
                    || (state_q == osfm_pkg::ST_ASLEEP && wakeFromSleep)
                    || (srcChange && state_q != osfm_pkg::ST_ASLEEP);

   // Counts external oscillations from zero after each restart
   always_comb begin
      state_d    = state_q;
      startCnt_d = startCnt_q;
      case (state_q)
         osfm_pkg::ST_POWERUP_WAIT,
         osfm_pkg::ST_ASLEEP,
         osfm_pkg::ST_READY: begin
            if (restart) begin
               startCnt_d = '0;
               state_d    = countMode ? osfm_pkg::ST_COUNTING : osfm_pkg::ST_READY;
            end
         end
         osfm_pkg::ST_COUNTING: begin
            if (restart) begin
               startCnt_d = '0;
            end else if (extFall) begin
               startCnt_d = startCnt_q + 1'b1;
               if (startCnt_q == CNT_LAST) begin
                  state_d = osfm_pkg::ST_READY;
               end
            end
         end
         default: state_d = osfm_pkg::ST_POWERUP_WAIT;
      endcase
      if (sleepEntry) begin
         state_d = osfm_pkg::ST_ASLEEP;
      end
   end

   // Sequencer flops
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q    <= osfm_pkg::ST_POWERUP_WAIT;
         startCnt_q <= '0;
      end else begin
         state_q    <= state_d;
         startCnt_q <= startCnt_d;
      end
   end

   // =========================================================
   // Sample clock divider and fail detector
   logic [DW-1:0] divCnt_q;
   logic [DW-1:0] divCnt_d;
   logic          latch_q;
   logic          latch_d;
   logic          sampleRise;
   logic          sampleFall;
   logic          failState_d;

   assign sampleRise = lfRise && divCnt_q == '1;
   assign sampleFall = lfRise && divCnt_q == DIV_HALF - 1'b1;
   // Whole half period with the latch still clear
   assign failDetect = sampleFall && !latch_q && !extFall && monitorEnable
                       && state_q == osfm_pkg::ST_READY && sysClkExternal
                       && !failState_q;

   // Divider, detector latch and fail state
   always_comb begin
      divCnt_d    = lfRise ? divCnt_q + 1'b1 : divCnt_q;
      latch_d     = latch_q;
      failState_d = failState_q;
      if (extFall) begin
         latch_d = 1'b1;
      end else if (sampleRise) begin
         latch_d = 1'b0;
      end
      if (failDetect) begin
         failState_d = 1'b1;
      end else if (sleepEntry || srcChange) begin
         failState_d = 1'b0;
      end
   end

   // Detector flops
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         divCnt_q    <= '0;
         latch_q     <= 1'b0;
         failState_q <= 1'b0;
      end else begin
         divCnt_q    <= divCnt_d;
         latch_q     <= latch_d;
         failState_q <= failState_d;
      end
   end

   // =========================================================
   // Outputs and read-back
   logic [7:0] rdData_d;
   logic [7:0] status;
   logic       sysExt_d;
   logic       hold_d;
   logic       irq_d;
   logic       started_d;

   assign status = {4'h0, state_q == osfm_pkg::ST_COUNTING, failState_q, sysClkExternal,
                    oscStarted};

   always_comb begin
      // External only after the count and with no failure pending
      sysExt_d  = srcSel_q == osfm_pkg::SRC_PRIMARY && state_q == osfm_pkg::ST_READY
                  && !failState_q && !srcChange;
      hold_d    = state_q == osfm_pkg::ST_COUNTING && !twoSpeedEff;
      irq_d     = failFlag_q && failIrqEn_q;
      started_d = state_q == osfm_pkg::ST_READY;
      rdData_d  = 8'h00;
      if (regRd) begin
         case (regAddr)
            osfm_pkg::OFS_OSC_CONTROL:   rdData_d = {1'b0, ifs_q, 1'b0, srcSel_q};
            osfm_pkg::OFS_OSC_STATUS:    rdData_d = status;
            osfm_pkg::OFS_IRQ_FLAGS_2:   rdData_d = {failFlag_q, 7'h00};
            osfm_pkg::OFS_IRQ_ENABLES_2: rdData_d = {failIrqEn_q, 7'h00};
            osfm_pkg::OFS_CONFIG:        rdData_d = config_q;
            default:                     rdData_d = 8'h00;
         endcase
      end
   end

   // Output flops
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdData          <= 8'h00;
         sysClkExternal     <= 1'b0;
         cpuHold            <= 1'b0;
         oscFailIrq         <= 1'b0;
         internalFreqSelect <= osfm_pkg::IFS_RESET;
         oscStarted         <= 1'b0;
      end else begin
         regRdData          <= rdData_d;
         sysClkExternal     <= sysExt_d;
         cpuHold            <= hold_d;
         oscFailIrq         <= irq_d;
         internalFreqSelect <= ifs_q;
         oscStarted         <= started_d;
      end
   end

   // =========================================================
   // Assertions
   sequence s_fail_seen;
      failDetect;
   endsequence

   sequence s_switch_away;
      ##1 failState_q ##1 !sysClkExternal;
   endsequence

   property p_count_done;
      @(posedge clk) disable iff (!reset_n)
      (state_q == osfm_pkg::ST_COUNTING && extFall && startCnt_q == CNT_LAST && !restart && !sleepEntry)
      |=> state_q == osfm_pkg::ST_READY;
   endproperty
   a_count_done: assert property (p_count_done) else $error("start-up count did not finish");

   property p_no_early_switch;
      @(posedge clk) disable iff (!reset_n)
      state_q == osfm_pkg::ST_COUNTING [*2] |-> !sysClkExternal;
   endproperty
   a_no_early_switch: assert property (p_no_early_switch) else $error("external used during count");

   property p_hold;
      @(posedge clk) disable iff (!reset_n)
      (state_q == osfm_pkg::ST_COUNTING) |=> cpuHold == !$past(twoSpeedEff);
   endproperty
   a_hold: assert property (p_hold) else $error("core hold wrong during count");

   property p_gate;
      @(posedge clk) disable iff (!reset_n)
      (!failState_q && !(monitorEnable && state_q == osfm_pkg::ST_READY)) |=> !failState_q;
   endproperty
   a_gate: assert property (p_gate) else $error("failure declared while not allowed");

   property p_switch;
      @(posedge clk) disable iff (!reset_n)
      s_fail_seen |-> s_switch_away ##0 failFlag_q;
   endproperty
   a_switch: assert property (p_switch) else $error("no switch to internal on failure");

   property p_irq;
      @(posedge clk) disable iff (!reset_n)
      (failFlag_q && failIrqEn_q) |=> oscFailIrq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_sleep_clear;
      @(posedge clk) disable iff (!reset_n)
      (sleepEntry && !failDetect) |=> !failState_q && state_q == osfm_pkg::ST_ASLEEP;
   endproperty
   a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear fail state");

   property p_skip;
      @(posedge clk) disable iff (!reset_n)
      (state_q == osfm_pkg::ST_POWERUP_WAIT && powerupDelayDone && !countMode && !sleepEntry)
      |=> state_q == osfm_pkg::ST_READY;
   endproperty
   a_skip: assert property (p_skip) else $error("count not skipped in clock or RC mode");

   property p_freq;
      @(posedge clk) disable iff (!reset_n)
      $changed(ifs_q) |=> internalFreqSelect == $past(ifs_q);
   endproperty
   a_freq: assert property (p_freq) else $error("internal frequency select not followed");

   property p_latch_set;
      @(posedge clk) disable iff (!reset_n)
      extFall |=> latch_q;
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set by falling edge");

   property p_latch_clear;
      @(posedge clk) disable iff (!reset_n)
      (sampleRise && !extFall) |=> !latch_q;
   endproperty
   a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared by sample clock");

   property p_restart_zero;
      @(posedge clk) disable iff (!reset_n)
      (restart && !sleepEntry) |=> startCnt_q == '0;
   endproperty
   a_restart_zero: assert property (p_restart_zero) else $error("start-up counter not cleared");

   property p_src_clear;
      @(posedge clk) disable iff (!reset_n)
      (srcChange && !failDetect) |=> !failState_q;
   endproperty
   a_src_clear: assert property (p_src_clear) else $error("source change did not clear fail state");

endmodule // osfm_top

// ---- verif/osfm_osc_model.sv ----
`timescale 1ns/1ns
// ==========================================
// Crystal and low-frequency oscillator stand-in
module osfm_osc_model #(
   parameter int EXT_HALF_NS = 73,
   parameter int LOW_HALF_NS = 231
) (
   input  wire logic run,
   output logic      extClk,
   output logic      lowFreqClk
);
   // Crystal output, frozen high once stopped
   initial begin
      extClk = 1'b1;
      forever begin
         #(EXT_HALF_NS);
         if (run) extClk = ~extClk;
         else extClk = 1'b1;
      end
   end
   // Internal oscillator runs free
   initial begin
      lowFreqClk = 1'b0;
      forever #(LOW_HALF_NS) lowFreqClk = ~lowFreqClk;
   end
endmodule // osfm_osc_model

// ---- verif/tb.sv ----
`timescale 1ns/1ns
// ==========================================
// Self-checking bench
module tb;
   localparam logic [2:0] CTL = osfm_pkg::OFS_OSC_CONTROL;
   localparam logic [2:0] STS = osfm_pkg::OFS_OSC_STATUS;
   localparam logic [2:0] FLG = osfm_pkg::OFS_IRQ_FLAGS_2;
   localparam logic [2:0] ENA = osfm_pkg::OFS_IRQ_ENABLES_2;
   localparam logic [2:0] CFG = osfm_pkg::OFS_CONFIG;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic       extRun = 1'b1;
   logic       extClkPin;
   logic       lowFreqOscPin;
   logic       powerupDelayDone = 1'b0;
   logic       sleepEntry = 1'b0;
   logic       wakeFromSleep = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [7:0] regWrData = 8'h00;
   logic       regWr = 1'b0;
   logic       regRd = 1'b0;
   logic [7:0] regRdData;
   logic       sysClkExternal;
   logic       cpuHold;
   logic       oscFailIrq;
   logic [3:0] internalFreqSelect;
   logic       oscStarted;
   int         badCount = 0;
   int         totalChecks = 0;
   int         n;
   logic [7:0] v;

   // Clock, 40 ns period
   always #20 clk = ~clk;

   osfm_osc_model i_osc (.run(extRun), .extClk(extClkPin), .lowFreqClk(lowFreqOscPin));

   osfm_top #(.STARTUP_COUNT(8), .SAMPLE_DIV(8)) i_dut (
      .clk(clk), .reset_n(reset_n), .extClkPin(extClkPin), .lowFreqOscPin(lowFreqOscPin),
      .powerupDelayDone(powerupDelayDone), .sleepEntry(sleepEntry), .wakeFromSleep(wakeFromSleep),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .sysClkExternal(sysClkExternal), .cpuHold(cpuHold), .oscFailIrq(oscFailIrq),
      .internalFreqSelect(internalFreqSelect), .oscStarted(oscStarted));

   // ==========================================
   // Shared tasks
   task automatic results();
      if (badCount == 0 && totalChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic limit(input int lim);
      if (n >= lim) begin
         badCount++;
         results();
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) begin
         regWr <= 1'b1;
         regAddr <= a;
         regWrData <= d;
      end
      @(posedge clk) regWr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk) begin
         regRd <= 1'b1;
         regAddr <= a;
      end
      @(posedge clk) regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask

   task automatic waitStarted();
      for (n = 0; n < 100 && oscStarted !== 1'b1; n++) step(1);
      limit(100);
   endtask

   task automatic waitFail();
      for (n = 0; n < 300 && sysClkExternal !== 1'b0; n++) step(1);
      limit(300);
   endtask

   // ==========================================
   // Scenarios
   task automatic s_reset();
      rd(CTL, v);
      chk(v, 8'h38);
      wr(3'h6, 8'hff);
      for (int a = 1; a < 8; a++) begin
         rd(a[2:0], v);
         chk(v, 8'h00);
      end
      chk({4'h0, internalFreqSelect}, 8'h07);
   endtask

   task automatic s_crystal();
      wr(CFG, 8'h04);
      @(posedge clk) powerupDelayDone <= 1'b1;
      @(posedge clk) powerupDelayDone <= 1'b0;
      step(4);
      chk({7'h0, cpuHold}, 8'h01);
      rd(STS, v);
      chk(v, 8'h08);
      waitStarted();
      chk({7'h0, n >= 12}, 8'h01);
      step(2);
      chk({6'h0, cpuHold, sysClkExternal}, 8'h01);
      rd(STS, v);
      chk(v, 8'h03);
   endtask

   task automatic s_wake();
      wr(CFG, 8'h05);
      @(posedge clk) sleepEntry <= 1'b1;
      @(posedge clk) sleepEntry <= 1'b0;
      step(3);
      @(posedge clk) wakeFromSleep <= 1'b1;
      @(posedge clk) wakeFromSleep <= 1'b0;
      step(4);
      chk({7'h0, cpuHold}, 8'h00);
      rd(STS, v);
      chk(v, 8'h08);
      waitStarted();
      step(2);
      chk({7'h0, sysClkExternal}, 8'h01);
   endtask

   task automatic s_fail();
      wr(ENA, 8'h80);
      wr(CTL, 8'h28);
      step(2);
      chk({4'h0, internalFreqSelect}, 8'h05);
      extRun <= 1'b0;
      waitFail();
      chk({7'h0, n >= 30}, 8'h01);
      step(1);
      chk({7'h0, oscFailIrq}, 8'h01);
      rd(FLG, v);
      chk(v, 8'h80);
      rd(STS, v);
      chk(v, 8'h05);
      step(100);
      chk({3'h0, sysClkExternal, internalFreqSelect}, 8'h05);
   endtask

   task automatic s_restart();
      wr(FLG, 8'h00);
      wr(CTL, 8'h29);
      rd(STS, v);
      chk(v & 8'h04, 8'h00);
      wr(CTL, 8'h28);
      step(200);
      chk({7'h0, sysClkExternal}, 8'h00);
      rd(FLG, v);
      chk(v, 8'h00);
      extRun <= 1'b1;
      waitStarted();
      step(2);
      chk({7'h0, sysClkExternal}, 8'h01);
      wr(CFG, 8'h0d);
      extRun <= 1'b0;
      waitFail();
      wr(FLG, 8'h00);
      wr(CTL, 8'h29);
      wr(CTL, 8'h28);
      step(1);
      chk({7'h0, oscStarted}, 8'h01);
      for (n = 0; n < 300 && oscFailIrq !== 1'b1; n++) step(1);
      limit(300);
      rd(FLG, v);
      chk(v, 8'h80);
   endtask

   task automatic s_midreset();
      @(posedge clk) reset_n <= 1'b0;
      step(3);
      @(posedge clk) reset_n <= 1'b1;
      step(1);
      rd(FLG, v);
      chk(v, 8'h00);
      rd(STS, v);
      chk(v, 8'h00);
      wr(CFG, 8'h0c);
      @(posedge clk) powerupDelayDone <= 1'b1;
      @(posedge clk) powerupDelayDone <= 1'b0;
      step(2);
      rd(STS, v);
      chk(v, 8'h03);
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      step(1);
      s_reset();
      s_crystal();
      s_wake();
      s_fail();
      s_restart();
      s_midreset();
      results();
   end
endmodule // tb
